// file: sfs_pkg.sv
// Behaviour
// - Serial output is high impedance while the device is deselected.
// - Serial input activity is ignored while deselected; nothing is captured.
// - Operation starts at select falling edge, ends at its rising edge.
// - Deselect with nothing pending enters standby, never deep power-down.
// - A started program or erase cycle completes before standby is entered.
// - Command, address and write data are sampled on serial clock rise.
// - Serial output changes only on serial clock falling edges.
// - Array has 1,024 pages of 256 or 264 bytes, selectable.
// - One SRAM buffer whose length equals the configured page size.
// - Erase by page, 2K block, 32K sector or chip; program per page.
// - Program and erase cycles are timed internally by the device.
// - 128-byte security register: 64 bytes user, 64 bytes fixed identifier.
// - Continuous read streams across page boundaries through the whole array.
// - Opcode of eight bits comes first, then the address.
// - All bytes are shifted most significant bit first.
package sfs_pkg;

  // ==========================================================
  // clock and array geometry
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned PAGE_W           = 10;
  localparam int unsigned BYTE_W           = 9;
  localparam logic [8:0]  PAGE_LEN_EXT     = 9'h108;
  localparam logic [8:0]  PAGE_LEN_P2      = 9'h100;
  localparam logic [9:0]  BLOCK_PAGE_MASK  = 10'h3f8;
  localparam logic [9:0]  SECTOR_PAGE_MASK = 10'h380;
  localparam int unsigned BUF_DEPTH        = 264;
  localparam int unsigned SEC_LEN          = 128;
  localparam logic [6:0]  SEC_USER_LEN     = 7'h40;
  localparam logic [7:0]  SEC_USER_RST     = 8'hff;
  // fixed identifier seed, arbitrary value
  localparam logic [7:0]  SEC_ID_SEED      = 8'h5a;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_ARR_RD   = 8'h0b;
  localparam logic [7:0] OP_BUF_RD   = 8'hd4;
  localparam logic [7:0] OP_BUF_WR   = 8'h84;
  localparam logic [7:0] OP_PROG     = 8'h83;
  localparam logic [7:0] OP_ERS_PG   = 8'h81;
  localparam logic [7:0] OP_ERS_BLK  = 8'h50;
  localparam logic [7:0] OP_ERS_SEC  = 8'h7c;
  localparam logic [7:0] OP_ERS_CHIP = 8'hc7;
  localparam logic [7:0] OP_SEC_RD   = 8'h77;
  localparam logic [7:0] OP_SEC_WR   = 8'h9b;

  // ==========================================================
  // self-timed cycle lengths in microseconds
  localparam int unsigned T_PROG_US    = 3000;
  localparam int unsigned T_ERS_PG_US  = 15000;
  localparam int unsigned T_ERS_BLK_US = 45000;
  localparam int unsigned T_ERS_SEC_US = 1600000;
  localparam int unsigned T_ERS_CH_US  = 3000000;
  localparam int unsigned T_SEC_WR_US  = 3000;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CMD_NONE     = 4'b0000,
    CMD_ARR_RD   = 4'b0001,
    CMD_BUF_RD   = 4'b0010,
    CMD_BUF_WR   = 4'b0011,
    CMD_PROG     = 4'b0100,
    CMD_ERS_PG   = 4'b0101,
    CMD_ERS_BLK  = 4'b0110,
    CMD_ERS_SEC  = 4'b0111,
    CMD_ERS_CHIP = 4'b1000,
    CMD_SEC_RD   = 4'b1001,
    CMD_SEC_WR   = 4'b1010
  } sfs_cmd_t;

  typedef enum logic [1:0] {
    PH_OP     = 2'b00,
    PH_ADDR   = 2'b01,
    PH_DATA   = 2'b10,
    PH_IGNORE = 2'b11
  } sfs_phase_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_COPY = 2'b01,
    ENG_WAIT = 2'b10
  } sfs_eng_t;

  typedef enum logic [1:0] {
    ERS_PAGE   = 2'b00,
    ERS_BLOCK  = 2'b01,
    ERS_SECTOR = 2'b10,
    ERS_CHIP   = 2'b11
  } sfs_ers_t;

endpackage

// file: sfs_sync.sv
`timescale 1ns/10ps
module sfs_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// file: sfs_timer.sv
`timescale 1ns/10ps
module sfs_timer #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  // status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_r;

  // counts load cycles after start, then pulses done
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        cnt_r <= load - 1'b1;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_r == '0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule

// file: sfs_top.sv
`timescale 1ns/10ps
module sfs_top #(
  parameter int unsigned CYC_PROG    = sfs_pkg::T_PROG_US * sfs_pkg::CLK_MHZ,
  parameter int unsigned CYC_ERS_PG  = sfs_pkg::T_ERS_PG_US * sfs_pkg::CLK_MHZ,
  parameter int unsigned CYC_ERS_BLK = sfs_pkg::T_ERS_BLK_US * sfs_pkg::CLK_MHZ,
  parameter int unsigned CYC_ERS_SEC = sfs_pkg::T_ERS_SEC_US * sfs_pkg::CLK_MHZ,
  parameter int unsigned CYC_ERS_CH  = sfs_pkg::T_ERS_CH_US * sfs_pkg::CLK_MHZ,
  parameter int unsigned CYC_SEC_WR  = sfs_pkg::T_SEC_WR_US * sfs_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // serial link
  input  wire logic                         cs_n,
  input  wire logic                         sck,
  input  wire logic                         si,
  output logic                              so,
  output logic                              so_oe,
  // configuration
  input  wire logic                         page_pow2,
  // array port
  output logic [sfs_pkg::PAGE_W-1:0]        mem_page,
  output logic [sfs_pkg::BYTE_W-1:0]        mem_byte,
  output logic                              mem_rd,
  input  wire logic [7:0]                   mem_rdata,
  output logic                              mem_wr,
  output logic [7:0]                        mem_wdata,
  output logic                              mem_erase,
  output sfs_pkg::sfs_ers_t                 mem_erase_kind,
  // status
  output logic                              busy,
  output logic                              standby
);
  import sfs_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [8:0] page_len(input logic pow2);
    return pow2 ? PAGE_LEN_P2 : PAGE_LEN_EXT;
  endfunction

  function automatic sfs_cmd_t cmd_decode(input logic [7:0] op);
    sfs_cmd_t c;
    unique case (op)
      OP_ARR_RD:   c = CMD_ARR_RD;
      OP_BUF_RD:   c = CMD_BUF_RD;
      OP_BUF_WR:   c = CMD_BUF_WR;
      OP_PROG:     c = CMD_PROG;
      OP_ERS_PG:   c = CMD_ERS_PG;
      OP_ERS_BLK:  c = CMD_ERS_BLK;
      OP_ERS_SEC:  c = CMD_ERS_SEC;
      OP_ERS_CHIP: c = CMD_ERS_CHIP;
      OP_SEC_RD:   c = CMD_SEC_RD;
      OP_SEC_WR:   c = CMD_SEC_WR;
      default:     c = CMD_NONE;
    endcase
    return c;
  endfunction

  function automatic logic is_sec(input sfs_cmd_t c);
    return (c == CMD_SEC_RD) || (c == CMD_SEC_WR);
  endfunction

  // 24-bit address to {page, byte}
  function automatic logic [18:0] addr_split(input logic [23:0] a,
                                             input logic pow2,
                                             input sfs_cmd_t c);
    logic [9:0] pg;
    logic [8:0] by;
    pg = pow2 ? a[17:8] : a[18:9];
    by = pow2 ? {1'b0, a[7:0]} : a[8:0];
    if (is_sec(c))
    begin
      pg = 10'h000;
      by = {2'b00, a[6:0]};
    end
    else if (c == CMD_BUF_RD || c == CMD_BUF_WR)
    begin
      pg = 10'h000;
    end
    return {pg, by};
  endfunction

  function automatic logic [18:0] ptr_next(input logic [18:0] p,
                                           input logic pow2,
                                           input sfs_cmd_t c);
    logic [9:0] pg;
    logic [8:0] by;
    pg = p[18:9];
    by = p[8:0] + 9'h001;
    if (is_sec(c))
      by = {2'b00, by[6:0]};
    else if (by >= page_len(pow2))
    begin
      by = 9'h000;
      if (c == CMD_ARR_RD)
        pg = pg + 10'h001;
    end
    return {pg, by};
  endfunction

  // ==========================================================
  // pin sampling and edges
  logic [3:0]  sync_q;
  logic        cs_s;
  logic        sck_s;
  logic        si_s;
  logic        pow2_s;
  logic        cs_d_r;
  logic        sck_d_r;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;

  sfs_sync #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({page_pow2, si, sck, ~cs_n}),
    .q       (sync_q)
  );

  assign cs_s   = ~sync_q[0]; // reads deselected out of reset, no false edge
  assign sck_s  = sync_q[1];
  assign si_s   = sync_q[2];
  assign pow2_s = sync_q[3];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r  <= cs_s;
      sck_d_r <= sck_s;
    end
  end

  assign cs_fall  = cs_d_r && !cs_s;
  assign cs_rise  = !cs_d_r && cs_s;
  assign sck_rise = !sck_d_r && sck_s && !cs_s;
  assign sck_fall = sck_d_r && !sck_s && !cs_s;

  // ==========================================================
  // command decode
  sfs_phase_t  phase_r;
  sfs_cmd_t    cmd_r;
  logic [2:0]  bit_cnt_r;
  logic [1:0]  addr_cnt_r;
  logic [7:0]  rx_r;
  logic [15:0] addr_r;
  logic [7:0]  rx_nxt;
  logic        byte_done;
  logic        addr_load;
  logic        rd_phase;
  logic        wr_byte;
  logic        pow2_r;
  sfs_eng_t    eng_r;

  assign rx_nxt    = {rx_r[6:0], si_s};
  assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
  assign addr_load = byte_done && phase_r == PH_ADDR && addr_cnt_r == 2'h2;
  assign rd_phase  = phase_r == PH_DATA &&
                     (cmd_r == CMD_ARR_RD || cmd_r == CMD_BUF_RD ||
                      cmd_r == CMD_SEC_RD);
  assign wr_byte   = byte_done && phase_r == PH_DATA &&
                     (cmd_r == CMD_BUF_WR || cmd_r == CMD_SEC_WR);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase_r    <= PH_IGNORE;
      cmd_r      <= CMD_NONE;
      bit_cnt_r  <= 3'h0;
      addr_cnt_r <= 2'h0;
      rx_r       <= 8'h00;
      addr_r     <= 16'h0000;
    end
    else if (cs_fall)
    begin
      // fresh decoder; commands refused while a cycle runs
      phase_r    <= (eng_r == ENG_IDLE) ? PH_OP : PH_IGNORE;
      cmd_r      <= CMD_NONE;
      bit_cnt_r  <= 3'h0;
      addr_cnt_r <= 2'h0;
    end
    else if (cs_s)
      phase_r <= PH_IGNORE;
    else if (sck_rise)
    begin
      rx_r      <= rx_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7)
      begin
        unique case (phase_r)
          PH_OP:
          begin
            cmd_r <= cmd_decode(rx_nxt);
            if (cmd_decode(rx_nxt) == CMD_NONE)
              phase_r <= PH_IGNORE;
            else if (cmd_decode(rx_nxt) == CMD_ERS_CHIP)
              phase_r <= PH_DATA;
            else
              phase_r <= PH_ADDR;
          end
          PH_ADDR:
          begin
            addr_r     <= {addr_r[7:0], rx_nxt};
            addr_cnt_r <= addr_cnt_r + 2'h1;
            if (addr_cnt_r == 2'h2)
              phase_r <= PH_DATA;
          end
          PH_DATA:   phase_r <= PH_DATA;
          PH_IGNORE: phase_r <= PH_IGNORE;
        endcase
      end
    end
  end

  // ==========================================================
  // pointer, buffer and security storage
  logic [18:0] ptr_r;
  logic        fetch_r;
  logic [2:0]  oidx_r;
  logic [7:0]  buf_mem [0:BUF_DEPTH-1];
  logic [7:0]  sec_mem [0:SEC_LEN-1];
  logic [8:0]  copy_idx_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ptr_r   <= 19'h00000;
      fetch_r <= 1'b0;
    end
    else
    begin
      fetch_r <= 1'b0;
      if (addr_load)
      begin
        ptr_r   <= addr_split({addr_r, rx_nxt}, pow2_r, cmd_r);
        fetch_r <= 1'b1;
      end
      else if (wr_byte)
        ptr_r <= ptr_next(ptr_r, pow2_r, cmd_r);
      else if (sck_fall && rd_phase && oidx_r == 3'h0)
      begin
        ptr_r   <= ptr_next(ptr_r, pow2_r, cmd_r);
        fetch_r <= 1'b1;
      end
    end
  end

  // single page buffer, sized by the page mode
  always_ff @(posedge clk_sys)
  begin
    if (wr_byte && cmd_r == CMD_BUF_WR && ptr_r[8:0] < page_len(pow2_r))
      buf_mem[ptr_r[8:0]] <= rx_nxt;
  end

  // user half writable, identifier half fixed
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SEC_LEN; i++)
        sec_mem[i] <= (i < SEC_USER_LEN) ? SEC_USER_RST
                                         : (SEC_ID_SEED ^ 8'(i));
    end
    else if (wr_byte && cmd_r == CMD_SEC_WR && ptr_r[6:0] < SEC_USER_LEN)
      sec_mem[ptr_r[6:0]] <= rx_nxt;
  end

  // ==========================================================
  // read data and serial output
  logic [7:0] dbyte_r;
  logic [6:0] osh_r;
  logic       mem_rd_d_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      dbyte_r <= 8'hff;
    else if (fetch_r && cmd_r == CMD_BUF_RD)
      dbyte_r <= (ptr_r[8:0] < page_len(pow2_r)) ? buf_mem[ptr_r[8:0]]
                                                 : 8'hff;
    else if (fetch_r && cmd_r == CMD_SEC_RD)
      dbyte_r <= sec_mem[ptr_r[6:0]];
    else if (mem_rd_d_r)
      dbyte_r <= mem_rdata;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      so     <= 1'b0;
      so_oe  <= 1'b0;
      osh_r  <= 7'h00;
      oidx_r <= 3'h0;
    end
    else if (cs_s || addr_load)
    begin
      so_oe  <= 1'b0;
      oidx_r <= 3'h0;
    end
    else if (sck_fall && rd_phase)
    begin
      so_oe  <= 1'b1;
      oidx_r <= oidx_r + 3'h1;
      if (oidx_r == 3'h0)
      begin
        so    <= dbyte_r[7];
        osh_r <= dbyte_r[6:0];
      end
      else
      begin
        so    <= osh_r[6];
        osh_r <= {osh_r[5:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // self-timed engine
  logic        tmr_start_r;
  logic [31:0] tmr_load_r;
  logic        tmr_busy;
  logic        tmr_done;
  logic [9:0]  eng_page_r;
  logic        op_end;

  assign op_end = cs_rise && phase_r == PH_DATA && eng_r == ENG_IDLE;

  sfs_timer #(.W(32)) u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tmr_start_r),
    .load    (tmr_load_r),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pow2_r <= 1'b0;
    else if (cs_s && eng_r == ENG_IDLE)
      pow2_r <= pow2_s;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      eng_r          <= ENG_IDLE;
      eng_page_r     <= 10'h000;
      copy_idx_r     <= 9'h000;
      tmr_start_r    <= 1'b0;
      tmr_load_r     <= 32'h0;
      mem_erase      <= 1'b0;
      mem_erase_kind <= ERS_PAGE;
    end
    else
    begin
      tmr_start_r <= 1'b0;
      mem_erase   <= 1'b0;
      unique case (eng_r)
        ENG_IDLE:
          if (op_end)
          begin
            eng_page_r <= ptr_r[18:9];
            copy_idx_r <= 9'h000;
            eng_r      <= ENG_WAIT;
            mem_erase  <= 1'b1;
            tmr_start_r <= 1'b1;
            unique case (cmd_r)
              CMD_PROG:
              begin
                eng_r       <= ENG_COPY;
                mem_erase   <= 1'b0;
                tmr_start_r <= 1'b0;
              end
              CMD_ERS_PG:
              begin
                mem_erase_kind <= ERS_PAGE;
                tmr_load_r     <= 32'(CYC_ERS_PG);
              end
              CMD_ERS_BLK:
              begin
                mem_erase_kind <= ERS_BLOCK;
                eng_page_r     <= ptr_r[18:9] & BLOCK_PAGE_MASK;
                tmr_load_r     <= 32'(CYC_ERS_BLK);
              end
              CMD_ERS_SEC:
              begin
                mem_erase_kind <= ERS_SECTOR;
                eng_page_r     <= ptr_r[18:9] & SECTOR_PAGE_MASK;
                tmr_load_r     <= 32'(CYC_ERS_SEC);
              end
              CMD_ERS_CHIP:
              begin
                mem_erase_kind <= ERS_CHIP;
                eng_page_r     <= 10'h000;
                tmr_load_r     <= 32'(CYC_ERS_CH);
              end
              CMD_SEC_WR:
              begin
                mem_erase  <= 1'b0;
                tmr_load_r <= 32'(CYC_SEC_WR);
              end
              default:
              begin
                eng_r       <= ENG_IDLE;
                mem_erase   <= 1'b0;
                tmr_start_r <= 1'b0;
              end
            endcase
          end
        ENG_COPY:
        begin
          copy_idx_r <= copy_idx_r + 9'h001;
          if (copy_idx_r == page_len(pow2_r) - 9'h001)
          begin
            eng_r       <= ENG_WAIT;
            tmr_start_r <= 1'b1;
            tmr_load_r  <= 32'(CYC_PROG);
          end
        end
        ENG_WAIT:
          if (tmr_done)
            eng_r <= ENG_IDLE;
        default:
          eng_r <= ENG_IDLE;
      endcase
    end
  end

  // ==========================================================
  // array port and status
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_page   <= 10'h000;
      mem_byte   <= 9'h000;
      mem_rd     <= 1'b0;
      mem_rd_d_r <= 1'b0;
      mem_wr     <= 1'b0;
      mem_wdata  <= 8'h00;
    end
    else
    begin
      mem_rd     <= fetch_r && cmd_r == CMD_ARR_RD;
      mem_rd_d_r <= mem_rd;
      mem_wr     <= eng_r == ENG_COPY;
      if (eng_r == ENG_COPY)
      begin
        mem_page  <= eng_page_r;
        mem_byte  <= copy_idx_r;
        mem_wdata <= buf_mem[copy_idx_r];
      end
      else if (fetch_r)
      begin
        mem_page <= ptr_r[18:9];
        mem_byte <= ptr_r[8:0];
      end
      else if (eng_r == ENG_IDLE && op_end)
      begin
        mem_page <= ptr_r[18:9];
        mem_byte <= 9'h000;
      end
      else if (mem_erase)
        mem_page <= eng_page_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy    <= 1'b0;
      standby <= 1'b0;
    end
    else
    begin
      busy    <= eng_r != ENG_IDLE || tmr_busy;
      standby <= cs_s && eng_r == ENG_IDLE && !op_end;
    end
  end

endmodule

// file: sfs_props.sv
`timescale 1ns/10ps
module sfs_props (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst,
  // serial link
  input wire logic                       cs_n,
  input wire logic                       sck,
  input wire logic                       so,
  input wire logic                       so_oe,
  input wire logic                       page_pow2,
  // array side and status
  input wire logic [sfs_pkg::PAGE_W-1:0] mem_page,
  input wire logic [sfs_pkg::BYTE_W-1:0] mem_byte,
  input wire logic                       mem_wr,
  input wire logic                       mem_erase,
  input wire sfs_pkg::sfs_ers_t          mem_erase_kind,
  input wire logic                       busy,
  input wire logic                       standby
);
  import sfs_pkg::*;
  // ==========================================================
  // cycles since the link clock last fell
  logic [3:0] fall_age_r;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      fall_age_r <= 4'hf;
    else if ($fell(sck))
      fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hf)
      fall_age_r <= fall_age_r + 4'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // properties
  property p_hiz; cs_n [*8] |-> !so_oe; endproperty
  property p_oe_sel; $rose(so_oe) |-> !cs_n; endproperty
  property p_so_fall;
    so_oe && $past(so_oe) && $changed(so) |-> !sck && fall_age_r < 4'h9;
  endproperty
  property p_busy_sby; busy |-> !standby; endproperty
  property p_sby; (cs_n && !busy) [*8] |-> standby; endproperty
  property p_busy_start; $rose(busy) |-> cs_n; endproperty
  property p_ers_end; mem_erase |-> cs_n && !$past(busy); endproperty
  property p_blk;
    mem_erase && mem_erase_kind == ERS_BLOCK |=> mem_page[2:0] == 3'h0;
  endproperty
  property p_sec;
    mem_erase && mem_erase_kind == ERS_SECTOR |=> mem_page[6:0] == 7'h00;
  endproperty
  property p_wr_len;
    mem_wr |-> busy && mem_byte < (page_pow2 ? PAGE_LEN_P2 : PAGE_LEN_EXT);
  endproperty
  a_hiz: assert property (p_hiz) else $error("so driven");
  a_oe_sel: assert property (p_oe_sel) else $error("oe unselected");
  a_so_fall: assert property (p_so_fall) else $error("so moved");
  a_busy_sby: assert property (p_busy_sby) else $error("standby");
  a_sby: assert property (p_sby) else $error("no standby");
  a_busy_start: assert property (p_busy_start) else $error("busy");
  a_ers_end: assert property (p_ers_end) else $error("erase");
  a_blk: assert property (p_blk) else $error("block align");
  a_sec: assert property (p_sec) else $error("sector align");
  a_wr_len: assert property (p_wr_len) else $error("write range");
  c_erase: cover property (mem_erase);
  c_read: cover property ($rose(so_oe));
  c_prog: cover property (mem_wr ##1 mem_wr);
endmodule

// file: sfs_host.sv
`timescale 1ns/10ps
module sfs_host (
  // clock
  input wire logic clk_sys,
  // serial link
  output logic     cs_n,
  output logic     sck,
  output logic     si,
  input wire logic so
);
  logic hold;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold = 1'b0;
  end
  // stale data never rests on si while deselected outside a frame
  always @(posedge clk_sys)
    if (cs_n && !hold)
      si <= ~si;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one bit of a 160 ns link clock, data set in the low phase
  task automatic shift(input logic d, output logic q);
    sck <= 1'b0;
    si <= d;
    wait_clk(10);
    sck <= 1'b1;
    q = so;
    wait_clk(10);
  endtask
  // frame of nb bits msb first; sel low gives deselected traffic
  task automatic frame(input bit m3, input logic [7:0] tx[$],
                       output logic [7:0] rx[$], input bit sel = 1,
                       input int nb = 0);
    logic [7:0] b;
    rx = {};
    if (nb == 0)
      nb = 8 * tx.size();
    hold = 1'b1;
    @(posedge clk_sys);
    sck <= m3;
    wait_clk(4);
    cs_n <= !sel;
    wait_clk(5);
    for (int n = 0; n < nb; n++)
    begin
      shift(tx[n/8][7-n%8], b[7-n%8]);
      if (n % 8 == 7)
        rx.push_back(b);
    end
    sck <= m3;
    wait_clk(10);
    cs_n <= 1'b1;
    wait_clk(10);
    hold = 1'b0;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  import sfs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, page_pow2, cs_n, sck, si, so, so_oe, busy, standby;
  logic mem_rd, mem_wr, mem_erase, ers_d;
  logic [PAGE_W-1:0] mem_page, wr_page, ers_page;
  logic [BYTE_W-1:0] mem_byte;
  logic [7:0] mem_rdata, mem_wdata, hi_wdata;
  sfs_ers_t mem_erase_kind, ers_kind;
  wire so_pin;
  int errors = 0, n_compared = 0, n_wr = 0, n_ers = 0, n_busy = 0;
  logic [7:0] rx[$];

  always #4 clk_sys = ~clk_sys;
  assign so_pin = so_oe ? so : ~so;

  sfs_top #(.CYC_PROG(20), .CYC_ERS_PG(24), .CYC_ERS_BLK(36),
    .CYC_ERS_SEC(48), .CYC_ERS_CH(60), .CYC_SEC_WR(20)) dut (
    .clk_sys, .rst, .cs_n, .sck, .si, .so, .so_oe, .page_pow2, .mem_page,
    .mem_byte, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .mem_erase,
    .mem_erase_kind, .busy, .standby);
  sfs_host host (.clk_sys, .cs_n, .sck, .si, .so(so_pin));

  // ==========================================================
  // array model and activity monitor
  always @(posedge clk_sys)
  begin
    if (mem_rd)
      mem_rdata <= mem_page[7:0] + mem_byte[7:0] + 8'h01;
    if (busy)
      n_busy++;
    if (mem_wr)
    begin
      n_wr++;
      wr_page = mem_page;
      if (mem_byte == 9'h107)
        hi_wdata = mem_wdata;
    end
    if (ers_d)
      ers_page = mem_page;
    ers_d = mem_erase;
    if (mem_erase)
    begin
      n_ers++;
      ers_kind = mem_erase_kind;
    end
  end

  // ==========================================================
  // helpers
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (standby !== 1'b1 && k < 4000)
    begin
      @(posedge clk_sys);
      k++;
    end
    check("idle wait", 1, standby);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    check("standby", 1, standby);
    check("so_oe", 0, so_oe);
  endtask
  task automatic t_buffer;
    host.frame(0, {8'h84, 8'h00, 8'h01, 8'h06, 8'ha1, 8'ha2, 8'ha3,
      8'ha4}, rx);
    host.frame(0, {8'hff, 8'hff}, rx, 0);
    check("standby", 1, standby);
    host.frame(0, {8'hff}, rx, 1, 3);
    host.frame(1, {8'hd4, 8'h00, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00,
      8'h00}, rx);
    for (int i = 0; i < 4; i++)
      check("buffer byte", 8'ha1 + i, rx[4+i]);
  endtask
  task automatic t_program;
    n_wr = 0;
    host.frame(0, {8'h83, 8'h00, 8'h0a, 8'h00}, rx);
    check("busy", 1, busy);
    check("standby", 0, standby);
    wait_idle();
    check("page writes", 264, n_wr);
    check("page", 10'h005, wr_page);
    check("last byte", 8'ha2, hi_wdata);
  endtask
  task automatic t_erase;
    logic [7:0] op [4] = '{8'h81, 8'h50, 8'h7c, 8'hc7};
    logic [9:0] pg [3] = '{10'h3ff, 10'h3f8, 10'h380};
    int tq [4] = '{24, 36, 48, 60};
    int n;
    for (int i = 0; i < 4; i++)
    begin
      n = n_ers;
      n_busy = 0;
      if (i < 3)
        host.frame(0, {op[i], 8'h07, 8'hfe, 8'h00}, rx);
      else
        host.frame(0, {op[i]}, rx);
      wait_idle();
      check("erase count", n + 1, n_ers);
      check("erase kind", i, ers_kind);
      if (i < 3)
        check("erase page", pg[i], ers_page);
      check("erase time", 1, n_busy >= tq[i] && n_busy <= tq[i] + 4);
    end
  endtask
  task automatic t_array;
    page_pow2 <= 1'b1;
    host.wait_clk(4);
    host.frame(1, {8'h0b, 8'h03, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00}, rx);
    check("array byte", 8'hfe, rx[4]);
    check("array byte", 8'hff, rx[5]);
    check("array byte", 8'h01, rx[6]);
  endtask
  task automatic t_security;
    host.frame(0, {8'h77, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00}, rx);
    check("user half", 8'hff, rx[4]);
    check("id half", SEC_ID_SEED ^ 8'h40, rx[5]);
    host.frame(0, {8'h9b, 8'h00, 8'h00, 8'h3f, 8'hc3, 8'h77}, rx);
    wait_idle();
    host.frame(1, {8'h77, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00}, rx);
    check("user write", 8'hc3, rx[4]);
    check("id fixed", SEC_ID_SEED ^ 8'h40, rx[5]);
  endtask

  initial
  begin
    rst = 1'b1;
    page_pow2 = 1'b0;
    mem_rdata = 8'h00;
    ers_d = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    t_reset();
    t_buffer();
    t_program();
    t_erase();
    t_array();
    t_security();
    summarize();
  end
  initial
  begin
    #600000;
    errors++;
    summarize();
  end
endmodule

bind sfs_top sfs_props u_props (.clk_sys, .rst, .cs_n, .sck, .so, .so_oe,
  .page_pow2, .mem_page, .mem_byte, .mem_wr, .mem_erase, .mem_erase_kind,
  .busy, .standby);
